//--- tmie_defines.svh
// Register offsets, event bit positions and reset values of the
// two-wire master interrupt-enable block.
// Assumes byte addresses on a 12-bit register port, 32-bit words.
`ifndef TMIE_DEFINES_SVH
`define TMIE_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define TMIE_OFS_ENABLE        12'h300
`define TMIE_OFS_ENABLE_SET    12'h304
`define TMIE_OFS_ENABLE_CLEAR  12'h308
`define TMIE_OFS_STATUS        12'h310
`define TMIE_OFS_STATUS_CLEAR  12'h314

////////////////////////////////////////////////////////////////////////////
// Event bit positions inside every register word
`define TMIE_BIT_STOPPED       5'h01
`define TMIE_BIT_ERROR         5'h09
`define TMIE_BIT_SUSPENDED     5'h12
`define TMIE_BIT_RX_BEGAN      5'h13
`define TMIE_BIT_TX_BEGAN      5'h14
`define TMIE_BIT_FINAL_RX      5'h17
`define TMIE_BIT_FINAL_TX      5'h18

////////////////////////////////////////////////////////////////////////////
// Reset values
`define TMIE_RST_ENABLE        7'h00
`define TMIE_RST_STATUS        7'h00
`define TMIE_RST_WORD          32'h0000_0000
`define TMIE_EVT_NONE          7'h00

`endif

//--- tmie_event_latch.sv
// Sticky event status bits, one for each of the seven events.
// Assumes one-cycle event pulses and clear masks on the same clock.
`timescale 1ns/1ns
`default_nettype none

`include "tmie_defines.svh"

module tmie_event_latch
  import tmie_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  tmie_evt_if.latch evt
);

  // Set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evt.status <= `TMIE_RST_STATUS;
    end else begin
      evt.status <= (evt.status & ~evt.status_clear) | evt.event_pulse;
    end
  end

endmodule

`default_nettype wire

//--- tmie_evt_if.sv
// Carrier between the register controller and the sticky event latch.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none

interface tmie_evt_if;
  import tmie_pkg::*;

  tmie_evt_t event_pulse;
  tmie_evt_t status_clear;
  tmie_evt_t status;

  modport ctrl (
    output event_pulse,
    output status_clear,
    input  status
  );

  modport latch (
    input  event_pulse,
    input  status_clear,
    output status
  );
endinterface

`default_nettype wire

//--- tmie_irq_ctrl.sv
// Interrupt-enable registers of the two-wire master, with sticky event
// status, a status clear register and one level interrupt output.
// Assumes event pulses come from logic on clk, and a register master
// that issues one-cycle strobes, never read and write together.
//
// Functional notes
// - Read/write enable bit for stopped event
// - Read/write enable bit for error event
// - Read/write enable bit for suspended event
// - Read/write enable bit for receive began
// - Read/write enable bit for transmit began
// - Read/write enable bit for final byte receive
// - Read/write enable bit for final byte transmit
// - Set view enables stopped, reads state back
// - Set view enables error, reads state back
// - Set view enables suspended, reads state back
// - Set view enables receive/transmit began
// - Set view enables final byte events
// - Clear view disables on one, reads back
// - Final receive enable gates its signalling
// - Final transmit enable gates its signalling
`timescale 1ns/1ns
`default_nettype none

`include "tmie_defines.svh"

module tmie_irq_ctrl
  import tmie_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire tmie_addr_t reg_addr,
  input  wire tmie_word_t reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output tmie_word_t      reg_rdata,
  input  wire logic       evt_stopped,
  input  wire logic       evt_error,
  input  wire logic       evt_suspended,
  input  wire logic       evt_receive_sequence_began,
  input  wire logic       evt_transmit_sequence_began,
  input  wire logic       evt_final_byte_receive,
  input  wire logic       evt_final_byte_transmit,
  output tmie_evt_t       evt_signal,
  output logic            irq
);

  ////////////////////////////////////////////////////////////////////////
  // Decoding and field mapping
  function automatic tmie_reg_sel_t sel_of(input tmie_addr_t addr);
    case (addr)
      `TMIE_OFS_ENABLE:       sel_of = TMIE_SEL_ENABLE;
      `TMIE_OFS_ENABLE_SET:   sel_of = TMIE_SEL_SET;
      `TMIE_OFS_ENABLE_CLEAR: sel_of = TMIE_SEL_CLEAR;
      `TMIE_OFS_STATUS:       sel_of = TMIE_SEL_STATUS;
      `TMIE_OFS_STATUS_CLEAR: sel_of = TMIE_SEL_STAT_CLEAR;
      default:                sel_of = TMIE_SEL_NONE;
    endcase
  endfunction

  // Event vector to register word; unused bits read as zero
  function automatic tmie_word_t to_word(input tmie_evt_t v);
    tmie_word_t w;
    w = `TMIE_RST_WORD;
    w[`TMIE_BIT_STOPPED]   = v[0];
    w[`TMIE_BIT_ERROR]     = v[1];
    w[`TMIE_BIT_SUSPENDED] = v[2];
    w[`TMIE_BIT_RX_BEGAN]  = v[3];
    w[`TMIE_BIT_TX_BEGAN]  = v[4];
    w[`TMIE_BIT_FINAL_RX]  = v[5];
    w[`TMIE_BIT_FINAL_TX]  = v[6];
    to_word = w;
  endfunction

  function automatic tmie_evt_t from_word(input tmie_word_t w);
    from_word = {w[`TMIE_BIT_FINAL_TX], w[`TMIE_BIT_FINAL_RX],
                 w[`TMIE_BIT_TX_BEGAN], w[`TMIE_BIT_RX_BEGAN],
                 w[`TMIE_BIT_SUSPENDED], w[`TMIE_BIT_ERROR],
                 w[`TMIE_BIT_STOPPED]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  tmie_evt_if    evt_bus ();
  tmie_evt_t     enable;
  tmie_evt_t     next_enable;
  tmie_evt_t     events;
  tmie_evt_t     wr_mask;
  tmie_reg_sel_t wr_sel;
  tmie_reg_sel_t rd_sel;
  tmie_word_t    next_rdata;

  assign wr_sel  = reg_wr ? sel_of(reg_addr) : TMIE_SEL_NONE;
  assign rd_sel  = reg_rd ? sel_of(reg_addr) : TMIE_SEL_NONE;
  assign wr_mask = from_word(reg_wdata);

  assign events = {evt_final_byte_transmit, evt_final_byte_receive,
                   evt_transmit_sequence_began,
                   evt_receive_sequence_began,
                   evt_suspended, evt_error, evt_stopped};

  ////////////////////////////////////////////////////////////////////////
  // Shared enable flops, reached through three views
  always_comb begin
    next_enable = enable;
    case (wr_sel)
      TMIE_SEL_ENABLE: begin
        // Each bit stores the written 1 or 0
        next_enable = wr_mask;
      end
      TMIE_SEL_SET: begin
        // Ones enable, zeros leave alone
        next_enable = enable | wr_mask;
      end
      TMIE_SEL_CLEAR: begin
        next_enable = enable & ~wr_mask;
      end
      TMIE_SEL_NONE,
      TMIE_SEL_STATUS,
      TMIE_SEL_STAT_CLEAR: begin
        next_enable = enable;
      end
      default: begin
        next_enable = enable;
      end
    endcase
  end

  // One register for all views so none can disagree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable <= `TMIE_RST_ENABLE;
    end else begin
      enable <= next_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status and its write-one-to-clear register
  assign evt_bus.event_pulse  = events;
  assign evt_bus.status_clear = (wr_sel == TMIE_SEL_STAT_CLEAR)
                                ? wr_mask : `TMIE_EVT_NONE;

  tmie_event_latch u_latch (
    .clk   (clk),
    .rst_b (rst_b),
    .evt   (evt_bus.latch)
  );

  // Level output straight from flops, no extra cycle of lag
  assign irq = |(evt_bus.status & enable);

  // Enabled events passed on one cycle later as pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_signal <= `TMIE_EVT_NONE;
    end else begin
      evt_signal <= events & enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path; data valid only in the cycle after the strobe
  always_comb begin
    case (rd_sel)
      TMIE_SEL_ENABLE: begin
        next_rdata = to_word(enable);
      end
      TMIE_SEL_SET: begin
        next_rdata = to_word(enable);
      end
      TMIE_SEL_CLEAR: begin
        next_rdata = to_word(enable);
      end
      TMIE_SEL_STATUS: begin
        next_rdata = to_word(evt_bus.status);
      end
      TMIE_SEL_NONE,
      TMIE_SEL_STAT_CLEAR: begin
        next_rdata = `TMIE_RST_WORD;
      end
      default: begin
        next_rdata = `TMIE_RST_WORD;
      end
    endcase
  end

  // Zero outside read answers keeps stale data off the bus
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `TMIE_RST_WORD;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

//--- tmie_irq_ctrl_assertions.sv
// Checker for the register port, read slot and irq of the block.
// Assumes it is bound onto tmie_irq_ctrl, one clock domain.
`timescale 1ns/1ns
`default_nettype none

module tmie_chk
  import tmie_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire tmie_addr_t reg_addr,
  input wire tmie_word_t reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire tmie_word_t reg_rdata,
  input wire tmie_evt_t  evt_signal,
  input wire logic       irq
);
  // The seven event positions
  localparam tmie_word_t M = 32'h019C_0202;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == '0) else $error("data off slot");
  AST_RD_STC: assert property (
    reg_rd && reg_addr == 12'h314 |=> reg_rdata == '0)
    else $error("clear view read not zero");
  AST_RD_MASK: assert property (
    (reg_rdata & ~M) == '0) else $error("stray read bits");
  AST_SET_RB: assert property (
    reg_wr && reg_addr == 12'h304 ##1 reg_rd && reg_addr == 12'h300
    |=> (reg_rdata & $past(reg_wdata, 2) & M) == ($past(reg_wdata, 2) & M))
    else $error("set bits not seen");
  AST_EN_RB: assert property (
    reg_wr && reg_addr == 12'h300 ##1 reg_rd && reg_addr == 12'h304
    |=> reg_rdata == ($past(reg_wdata, 2) & M))
    else $error("enable not seen in set view");
  AST_CLR_RB: assert property (
    reg_wr && reg_addr == 12'h308 ##1 reg_rd && reg_addr == 12'h308
    |=> (reg_rdata & $past(reg_wdata, 2)) == '0)
    else $error("cleared bit still set");
  AST_IRQ_EVT: assert property (
    |evt_signal && !$past(reg_wr) |-> irq) else $error("irq missing");
  AST_EN_OFF: assert property (
    reg_wr && reg_addr == 12'h300 && reg_wdata == '0 |=> !irq)
    else $error("irq with all disabled");
endmodule

bind tmie_irq_ctrl tmie_chk u_chk (
  .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .evt_signal, .irq
);

`default_nettype wire

//--- tmie_pkg.sv
// Types shared by the interrupt-enable block and its event latch.
// Assumes tmie_defines.svh is compiled alongside.
package tmie_pkg;

  typedef logic [31:0] tmie_word_t;
  typedef logic [11:0] tmie_addr_t;

  // Index 0 stopped, 1 error, 2 suspended, 3 rx began, 4 tx began,
  // 5 final rx byte, 6 final tx byte
  typedef logic [6:0]  tmie_evt_t;

  typedef enum logic [5:0] {
    TMIE_SEL_NONE       = 6'h01,
    TMIE_SEL_ENABLE     = 6'h02,
    TMIE_SEL_SET        = 6'h04,
    TMIE_SEL_CLEAR      = 6'h08,
    TMIE_SEL_STATUS     = 6'h10,
    TMIE_SEL_STAT_CLEAR = 6'h20
  } tmie_reg_sel_t;

endpackage

//--- tmie_tb.sv
// Self-checking bench for the interrupt-enable block.
// Assumes design files and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none

module testbench
  import tmie_pkg::*;
;
  logic       clk;
  logic       rst_b;
  tmie_addr_t reg_addr;
  tmie_word_t reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  tmie_word_t reg_rdata;
  tmie_evt_t  ev;
  tmie_evt_t  evt_signal;
  logic       irq;
  tmie_evt_t  en;
  tmie_evt_t  st;
  int         bad_count = 0;
  int         n_tests = 0;
  int         seed;
  tmie_word_t r;
  tmie_addr_t tbl [8];

  tmie_irq_ctrl u_dut (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .evt_signal, .irq,
    .evt_stopped(ev[0]), .evt_error(ev[1]), .evt_suspended(ev[2]),
    .evt_receive_sequence_began(ev[3]),
    .evt_transmit_sequence_began(ev[4]),
    .evt_final_byte_receive(ev[5]), .evt_final_byte_transmit(ev[6])
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic tmie_word_t tw(tmie_evt_t e);
    return {7'h00, e[6:5], 2'h0, e[4:2], 8'h00, e[1], 7'h00, e[0], 1'h0};
  endfunction
  function automatic tmie_evt_t fw(tmie_word_t w);
    return {w[24:23], w[20:18], w[9], w[1]};
  endfunction
  function automatic tmie_word_t rexp(tmie_addr_t a);
    case (a)
      12'h300, 12'h304, 12'h308: return tw(en);
      12'h310: return tw(st);
      default: return '0;
    endcase
  endfunction

  task automatic chk_w(tmie_word_t g, tmie_word_t x);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %0t word %h not %h", $time, g, x);
    end
  endtask
  task automatic chk_b(logic g, logic x);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %0t irq %b not %b", $time, g, x);
    end
  endtask

  // Write, then read back at once so views are seen back to back
  task automatic wr(tmie_addr_t a, tmie_word_t d, tmie_addr_t ra);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr   <= 1'h0;
    reg_rd   <= 1'h1;
    reg_addr <= ra;
    case (a)
      12'h300: en = fw(d);
      12'h304: en = en | fw(d);
      12'h308: en = en & ~fw(d);
      12'h314: st = st & ~fw(d);
      default: ;
    endcase
    @(negedge clk);
    chk_b(irq, |(st & en));
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    chk_w(reg_rdata, rexp(ra));
  endtask

  task automatic evt(tmie_evt_t e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    st = st | e;
    @(negedge clk);
    chk_w({25'h0, evt_signal}, {25'h0, e & en});
    chk_b(irq, |(st & en));
  endtask

  // Event in the clearing cycle of its own status bit must survive
  task automatic clr_evt(tmie_evt_t e);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= 12'h314;
    reg_wdata <= '1;
    ev        <= e;
    @(posedge clk);
    reg_wr <= 1'h0;
    ev     <= '0;
    st = e;
    @(negedge clk);
    chk_w({25'h0, evt_signal}, {25'h0, e & en});
    chk_b(irq, |(st & en));
  endtask

  task automatic results();
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Run needs about 850 cycles
  initial begin
    #200000;
    bad_count++;
    results();
  end

  initial begin
    rst_b = 1'h0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    ev = '0;
    en = '0;
    st = '0;
    seed = 32'h52160308;
    tbl = '{12'h300, 12'h304, 12'h308, 12'h310,
            12'h314, 12'h30C, 12'h302, 12'h000};
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    foreach (tbl[i]) wr(12'h000, '1, tbl[i]);
    wr(12'h300, '1, 12'h304);
    wr(12'h304, '0, 12'h300);
    wr(12'h308, 32'h0000_0200, 12'h308);
    for (int i = 0; i < 7; i++) evt(7'h01 << i);
    wr(12'h314, '1, 12'h310);
    wr(12'h300, '0, 12'h300);
    evt(7'h7F);
    wr(12'h304, 32'h0180_0000, 12'h304);
    wr(12'h310, '0, 12'h310);
    wr(12'h304, 32'h001C_0202, 12'h300);
    clr_evt(7'h21);
    wr(12'h000, '0, 12'h310);
    repeat (300) begin
      r = $random(seed);
      if (r[0]) evt(r[7:1]);
      else wr(tbl[r[3:1]], $random(seed), tbl[r[6:4]]);
    end
    results();
  end
endmodule

`default_nettype wire
